// file: ccg_regs.svh
/*
 Register offsets, reset values, field positions and timing counts of the
 clock output gate and reference select block.
 Assumes a 200 MHz aclk and AXI4-Lite byte addressing with 32-bit data.
*/
// Functional notes
// - Nine pairs, own enable bit, registers 0x00-0x08
// - Enable bits active high, reset to one
// - Hundred MHz pairs run with supply good and enable
// - Same gating for 25 MHz and selectable pairs
// - Disabled pair holds both legs low
// - Reference present: local 25 MHz locks to it
// - Reference absent: local 25 MHz from crystal
// - Missing reference drives open-drain indication low
// - Register access only while supply good high
`ifndef CCG_REGS_SVH
`define CCG_REGS_SVH

// Register byte addresses
`define CCG_ADDR_OE100    8'h00
`define CCG_ADDR_OE25     8'h04
`define CCG_ADDR_OEMX     8'h08
`define CCG_ADDR_MXSEL    8'h0c
`define CCG_ADDR_STAT     8'h10
`define CCG_ADDR_IRQST    8'h14
`define CCG_ADDR_IRQMSK   8'h18

// Field positions and reset values
`define CCG_OE100_RST     6'h3f
`define CCG_OE25_BIT      2
`define CCG_OEMX_LSB      1
`define CCG_OEMX_RST      2'h3
`define CCG_MXSEL_RST     2'h0
`define CCG_IRQMSK_RST    4'h0
`define CCG_IRQ_REF_LOST  0
`define CCG_IRQ_REF_FOUND 1
`define CCG_IRQ_SUP_FALL  2
`define CCG_IRQ_SUP_RISE  3

// Output pair indices
`define CCG_NPAIRS        9
`define CCG_PAIR_25       6
`define CCG_PAIR_MX0      7

// Bus answers
`define CCG_RESP_OKAY     2'h0
`define CCG_RESP_SLVERR   2'h2

// Timing
`define CCG_CLK_MHZ       200
`define CCG_PERIOD25_NS   40
`define CCG_DIV25_CYC     ((`CCG_PERIOD25_NS * `CCG_CLK_MHZ) / 1000)
`define CCG_REF_LOSS_NS   160
`define CCG_REF_LOSS_CYC  ((`CCG_REF_LOSS_NS * `CCG_CLK_MHZ) / 1000)
`define CCG_HALF25_CYC    (`CCG_DIV25_CYC / 2)

`endif

// file: ccg_pkg.sv
/*
 Types shared by the clock output gate and reference select block.
 Assumes ccg_regs.svh supplies the numeric constants.
*/
`default_nettype none
package ccg_pkg;
	typedef logic [1:0] ccg_resp_t;
	typedef logic [8:0] ccg_pairs_t;

	// Source of the local 25 MHz phase
	typedef enum logic [1:0]
	{
		CCG_SRC_XTAL = 2'b01,
		CCG_SRC_REF  = 2'b10
	} ccg_src_t;

	// Rising edge of a synchronised level
	function automatic logic ccg_rise(input logic prev, input logic cur);
		return cur & ~prev;
	endfunction
endpackage
`default_nettype wire

// file: ccg_gate_if.sv
/*
 Carrier between the control logic and the output gate stage.
 Assumes both ends run on aclk.
*/
`timescale 1ns/10ps
`default_nettype none
interface ccg_gate_if;
	logic [8:0] src;   // Free running source levels
	logic [8:0] req;   // Requested run state
	logic [8:0] run;   // Applied run state
	logic [8:0] out_t; // True legs
	logic [8:0] out_c; // Complement legs

	modport gate (input src, input req, output run, output out_t, output out_c);
	modport ctl  (output src, output req, input run, input out_t, input out_c);
endinterface
`default_nettype wire

// file: ccg_out_gate.sv
/*
 Output gate stage: per pair run state and registered legs.
 Assumes source levels are flops on aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ccg_out_gate
(
	input  wire logic aclk,
	input  wire logic aresetn,
	ccg_gate_if.gate  g
);
	import ccg_pkg::*;

	logic [8:0] run;

	// Run state moves only during the low phase of its source
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			run <= 9'h000;
		else
			run <= (run & g.src) | (g.req & ~g.src);
	end

	// Legs follow the source while running, both low otherwise
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			g.out_t <= 9'h000;
			g.out_c <= 9'h000;
		end
		else
		begin
			g.out_t <= g.src & run;
			g.out_c <= ~g.src & run;
		end
	end

	assign g.run = run;

	a_stop_legs_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(run == 9'h000) |=> (g.out_t == 9'h000) && (g.out_c == 9'h000))
		else $error("legs not low while stopped");

	a_run_change_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(run != $past(run)) |-> (($past(run) ^ run) & $past(g.src)) == 9'h000)
		else $error("run state changed in high phase");

	a_true_no_runt: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(g.out_t[0]) |-> $past(run[0], 2) || !$past(g.src[0], 2))
		else $error("true leg started mid high phase");
endmodule // ccg_out_gate
`default_nettype wire

// file: ccg_top.sv
/*
 Clock output gate and reference select top: AXI4-Lite register slave,
 input synchronisers, reference presence detection, local 25 MHz phase
 and the pair sources handed to the gate stage.
 Assumes aclk at 200 MHz; pins are asynchronous to aclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccg_regs.svh"
module ccg_top
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output var ccg_pkg::ccg_resp_t s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output var ccg_pkg::ccg_resp_t s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              supply_good_in,
	input  wire logic              platform_time_ref_in,
	input  wire logic              crystal_or_ext_ref_in,
	output logic [5:0]             hundred_mhz_out_t,
	output logic [5:0]             hundred_mhz_out_c,
	output logic                   twentyfive_mhz_out_t,
	output logic                   twentyfive_mhz_out_c,
	output logic [1:0]             selectable_freq_out_t,
	output logic [1:0]             selectable_freq_out_c,
	output logic                   platform_time_missing_n_o,
	output logic                   platform_time_missing_n_oe,
	output logic                   irq
);
	import ccg_pkg::*;

	localparam int LOSS = `CCG_REF_LOSS_CYC;

	logic [2:0] sup_sync;
	logic [2:0] ref_sync;
	logic [2:0] xtal_sync;
	logic       sup_ok;
	logic       sup_rise;
	logic       sup_fall;
	logic       ref_rise;
	logic       xtal_rise;
	logic [5:0] ref_cnt;
	logic       ref_missing;
	ccg_src_t   src_state;
	ccg_src_t   next_src_state;
	logic [2:0] ph25;
	logic       lvl25;
	logic       hund_lvl;
	logic [5:0] oe100;
	logic       oe25;
	logic [1:0] oemx;
	logic [1:0] mxsel;
	logic [3:0] irq_st;
	logic [3:0] irq_msk;
	logic [3:0] irq_ev;
	logic [3:0] irq_clr;
	logic       aw_hold;
	logic       w_hold;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic       wr_fire;
	logic       wr_ok;
	logic       wr_hit;
	logic [31:0] rd_word;
	logic       rd_hit;

	ccg_gate_if g ();

	// Two-stage synchronisers, third stage only for edge detection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sup_sync  <= 3'h0;
			ref_sync  <= 3'h0;
			xtal_sync <= 3'h0;
		end
		else
		begin
			sup_sync  <= {sup_sync[1:0], supply_good_in};
			ref_sync  <= {ref_sync[1:0], platform_time_ref_in};
			xtal_sync <= {xtal_sync[1:0], crystal_or_ext_ref_in};
		end
	end

	assign sup_ok    = sup_sync[1];
	assign sup_rise  = ccg_rise(sup_sync[2], sup_sync[1]);
	assign sup_fall  = ccg_rise(sup_sync[1], sup_sync[2]);
	assign ref_rise  = ccg_rise(ref_sync[2], ref_sync[1]);
	assign xtal_rise = ccg_rise(xtal_sync[2], xtal_sync[1]);

	// Reference presence: lost after LOSS cycles without a rising edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_cnt     <= 6'h00;
			ref_missing <= 1'b1;
		end
		else if (ref_rise)
		begin
			ref_cnt     <= 6'h00;
			ref_missing <= 1'b0;
		end
		else if (ref_cnt < 6'(LOSS))
			ref_cnt <= ref_cnt + 6'h01;
		else
			ref_missing <= 1'b1;
	end

	// Open-drain indication pulls low while the reference is absent
	assign platform_time_missing_n_o  = 1'b0;
	assign platform_time_missing_n_oe = ref_missing;

	// Phase source select follows reference presence
	always_comb
	begin
		next_src_state = src_state;
		unique case (src_state)
			CCG_SRC_XTAL:
				if (!ref_missing)
					next_src_state = CCG_SRC_REF;
			CCG_SRC_REF:
				if (ref_missing)
					next_src_state = CCG_SRC_XTAL;
			default:
				next_src_state = CCG_SRC_XTAL;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			src_state <= CCG_SRC_XTAL;
		else
			src_state <= next_src_state;
	end

	// Local 25 MHz phase, realigned on each rising edge of the chosen source
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ph25 <= 3'h0;
		else if (src_state == CCG_SRC_REF && ref_rise)
			ph25 <= 3'h1;
		else if (src_state == CCG_SRC_XTAL && xtal_rise)
			ph25 <= 3'h1;
		else if (ph25 == 3'(`CCG_DIV25_CYC - 1))
			ph25 <= 3'h0;
		else
			ph25 <= ph25 + 3'h1;
	end

	// 25 MHz level is high for the first half of the phase
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lvl25 <= 1'b0;
		else
			lvl25 <= (ph25 < 3'(`CCG_HALF25_CYC));
	end

	// 100 MHz level toggles every cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hund_lvl <= 1'b0;
		else
			hund_lvl <= ~hund_lvl;
	end

	// Pair sources and gate requests
	// One driver per carrier vector: pairs 8..7 selectable, 6 is 25 MHz, 5..0 are 100 MHz
	assign g.src = {mxsel[1] ? lvl25 : hund_lvl, mxsel[0] ? lvl25 : hund_lvl, lvl25, {6{hund_lvl}}};
	assign g.req = {oemx & {2{sup_ok}},
		oe25 & sup_ok,
		oe100 & {6{sup_ok}}};

	ccg_out_gate u_gate
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.g       (g)
	);

	assign hundred_mhz_out_t     = g.out_t[5:0];
	assign hundred_mhz_out_c     = g.out_c[5:0];
	assign twentyfive_mhz_out_t  = g.out_t[`CCG_PAIR_25];
	assign twentyfive_mhz_out_c  = g.out_c[`CCG_PAIR_25];
	assign selectable_freq_out_t = g.out_t[8:7];
	assign selectable_freq_out_c = g.out_c[8:7];

	// Write address and data are held until both are present
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;
	assign wr_ok         = wr_fire && sup_ok && wstrb_q[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold  <= 1'b0;
			awaddr_q <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold  <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_hold <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_hold  <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold  <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_hold <= 1'b0;
	end

	// Write address decode
	always_comb
	begin
		unique case (awaddr_q)
			`CCG_ADDR_OE100, `CCG_ADDR_OE25, `CCG_ADDR_OEMX, `CCG_ADDR_MXSEL,
			`CCG_ADDR_STAT, `CCG_ADDR_IRQST, `CCG_ADDR_IRQMSK:
				wr_hit = 1'b1;
			default:
				wr_hit = 1'b0;
		endcase
	end

	// Write response; supply low or unmapped answers SLVERR
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CCG_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (sup_ok && wr_hit) ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Output enable registers, all enabled out of reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oe100 <= `CCG_OE100_RST;
			oe25  <= 1'b1;
			oemx  <= `CCG_OEMX_RST;
		end
		else if (wr_ok)
		begin
			if (awaddr_q == `CCG_ADDR_OE100)
				oe100 <= wdata_q[5:0];
			if (awaddr_q == `CCG_ADDR_OE25)
				oe25 <= wdata_q[`CCG_OE25_BIT];
			if (awaddr_q == `CCG_ADDR_OEMX)
				oemx <= wdata_q[`CCG_OEMX_LSB +: 2];
		end
	end

	// Selectable pair frequency and interrupt mask
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mxsel   <= `CCG_MXSEL_RST;
			irq_msk <= `CCG_IRQMSK_RST;
		end
		else if (wr_ok)
		begin
			if (awaddr_q == `CCG_ADDR_MXSEL)
				mxsel <= wdata_q[`CCG_OEMX_LSB +: 2];
			if (awaddr_q == `CCG_ADDR_IRQMSK)
				irq_msk <= wdata_q[3:0];
		end
	end

	// Sticky events, write one to clear, a new event wins
	assign irq_ev[`CCG_IRQ_REF_LOST]  = (src_state == CCG_SRC_REF) && ref_missing;
	assign irq_ev[`CCG_IRQ_REF_FOUND] = (src_state == CCG_SRC_XTAL) && !ref_missing;
	assign irq_ev[`CCG_IRQ_SUP_FALL]  = sup_fall;
	assign irq_ev[`CCG_IRQ_SUP_RISE]  = sup_rise;
	assign irq_clr = (wr_ok && awaddr_q == `CCG_ADDR_IRQST) ? wdata_q[3:0] : 4'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_st <= 4'h0;
			irq    <= 1'b0;
		end
		else
		begin
			irq_st <= (irq_st & ~irq_clr) | irq_ev;
			irq    <= |(irq_st & irq_msk);
		end
	end

	// Read mux
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			`CCG_ADDR_OE100:  rd_word[5:0] = oe100;
			`CCG_ADDR_OE25:   rd_word[`CCG_OE25_BIT] = oe25;
			`CCG_ADDR_OEMX:   rd_word[`CCG_OEMX_LSB +: 2] = oemx;
			`CCG_ADDR_MXSEL:  rd_word[`CCG_OEMX_LSB +: 2] = mxsel;
			`CCG_ADDR_STAT:   rd_word[12:0] = {g.run, src_state == CCG_SRC_REF, sup_ok, 1'b0, ~ref_missing};
			`CCG_ADDR_IRQST:  rd_word[3:0] = irq_st;
			`CCG_ADDR_IRQMSK: rd_word[3:0] = irq_msk;
			default:          rd_hit = 1'b0;
		endcase
	end

	// Read channel, answer one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `CCG_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= (sup_ok && rd_hit) ? rd_word : 32'h0000_0000;
			s_axi_rresp  <= (sup_ok && rd_hit) ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	a_oe_reset_all: assert property (@(posedge aclk)
		$rose(aresetn) |-> (oe100 == 6'h3f) && oe25 && (oemx == 2'h3))
		else $error("enables not set after reset");

	a_supply_stops: assert property (@(posedge aclk) disable iff (!aresetn)
		(!sup_ok && $past(!sup_ok, 8)) |-> (g.run == 9'h000))
		else $error("pair running without supply good");

	a_oe_stops_25: assert property (@(posedge aclk) disable iff (!aresetn)
		(!oe25 && $past(!oe25, 8)) |-> !g.run[6] && !twentyfive_mhz_out_t)
		else $error("25 MHz pair running while disabled");

	a_runs_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
		(sup_ok && oe100[0]) [*4] |=> g.run[0])
		else $error("enabled pair not running");

	a_ref_lock: assert property (@(posedge aclk) disable iff (!aresetn)
		(src_state == CCG_SRC_REF && ref_rise) |=> (ph25 == 3'h1) ##1 lvl25)
		else $error("25 MHz phase not aligned to reference");

	a_xtal_source: assert property (@(posedge aclk) disable iff (!aresetn)
		ref_missing |-> ##[0:1] (src_state == CCG_SRC_XTAL))
		else $error("crystal not selected without reference");

	a_missing_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ref_rise && ref_cnt == 6'(LOSS)) |=> platform_time_missing_n_oe && !platform_time_missing_n_o)
		else $error("missing indication not asserted");

	a_ref_present: assert property (@(posedge aclk) disable iff (!aresetn)
		ref_rise |=> !platform_time_missing_n_oe)
		else $error("missing indication with reference edge");

	a_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && !sup_ok) |=> s_axi_bvalid && (s_axi_bresp == 2'h2) && $stable(oe100) && $stable(oemx))
		else $error("write accepted without supply good");

	a_w1c_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
		(irq_ev[2] && irq_clr[2]) |=> irq_st[2])
		else $error("event lost to clear");
endmodule // ccg_top
`default_nettype wire

// file: ccg_ref_src_model.sv
/*
 Partner clocks: free running crystal and switchable platform time reference.
 Assumes the bench switches the reference with ref_on at any time.
*/
`timescale 1ns/10ps
`default_nettype none
module ccg_ref_src_model
(
	input  wire logic ref_on,
	output logic      xtal_out,
	output logic      ref_out
);
	logic ref_ph;
	logic ref_gate;

	// Crystal, 40 ns period
	initial
	begin
		xtal_out = 1'h0;
		forever #20 xtal_out = ~xtal_out;
	end

	// Reference phase, offset from the crystal
	initial
	begin
		ref_ph = 1'h0;
		#7.3;
		forever #20 ref_ph = ~ref_ph;
	end

	// Start and stop only while low, so a stopped reference rests low
	initial ref_gate = 1'h0;
	always @(negedge ref_ph) ref_gate <= ref_on;
	assign ref_out = ref_ph & ref_gate;
endmodule // ccg_ref_src_model
`default_nettype wire

// file: clock_output_gate_and_ref_select_test.sv
/*
 Self-checking bench: register access, output gating, reference presence, irq.
 Assumes ccg_pkg, ccg_regs.svh and ccg_ref_src_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ccg_regs.svh"
module clock_output_gate_and_ref_select_test;
	import ccg_pkg::*;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h0;
	logic        s_axi_awvalid = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic [7:0]  s_axi_araddr = 8'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	logic        supply_good_in = 1'h1;
	logic        ref_on = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	ccg_resp_t   s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd;
	logic        platform_time_ref_in, crystal_or_ext_ref_in;
	logic        platform_time_missing_n_o, platform_time_missing_n_oe;
	logic [5:0]  hundred_mhz_out_t, hundred_mhz_out_c;
	logic        twentyfive_mhz_out_t, twentyfive_mhz_out_c;
	logic [1:0]  selectable_freq_out_t, selectable_freq_out_c;
	logic [8:0]  leg_t, leg_c;
	logic        mon_on = 1'h0;
	int          err_count = 0, checks_done = 0, cyc = 0, runts = 0, hr6 = 0, hr7 = 0;
	int          rise_t[9], same_n[9], high_n[9];

	always #2.5 aclk = ~aclk;

	ccg_ref_src_model i_src (.ref_on, .xtal_out(crystal_or_ext_ref_in), .ref_out(platform_time_ref_in));

	ccg_top i_dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.supply_good_in, .platform_time_ref_in, .crystal_or_ext_ref_in,
		.hundred_mhz_out_t, .hundred_mhz_out_c, .twentyfive_mhz_out_t, .twentyfive_mhz_out_c,
		.selectable_freq_out_t, .selectable_freq_out_c,
		.platform_time_missing_n_o, .platform_time_missing_n_oe, .irq
	);

	// All pairs as one vector, pair index order
	assign leg_t = {selectable_freq_out_t, twentyfive_mhz_out_t, hundred_mhz_out_t};
	assign leg_c = {selectable_freq_out_c, twentyfive_mhz_out_c, hundred_mhz_out_c};

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			end_sim();
		end
	end

	// Short high runs on the true legs of the 25 MHz pair 6 and selectable pair 7
	always @(posedge aclk)
	begin
		if (leg_t[6] === 1'h1)
			hr6++;
		else
		begin
			if (mon_on && hr6 > 0 && hr6 < 4)
				runts++;
			hr6 = 0;
		end
		if (leg_t[7] === 1'h1)
			hr7++;
		else
		begin
			if (mon_on && hr7 > 0 && hr7 < 4)
				runts++;
			hr7 = 0;
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Write: address and data offered together, each released when taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output ccg_resp_t r);
		logic done;
		done = 1'h0;
		// Own edge, so a ready lowered by the last call is not raised again in one step
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'h1)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready === 1'h1)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				done = 1'h1;
			end
		end
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output ccg_resp_t r);
		logic done;
		done = 1'h0;
		// Own edge, so a ready lowered by the last call is not raised again in one step
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'h1)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1)
			begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				done = 1'h1;
			end
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, 4'hf, resp);
		check("bresp", resp, `CCG_RESP_OKAY);
	endtask

	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		axi_read(a, rd, resp);
		check(n, rd, e);
		check("rresp", resp, `CCG_RESP_OKAY);
	endtask

	// Mode per pair, two bits each: 0 off, 1 at 100 MHz, 2 at 25 MHz
	task automatic check_pairs(input logic [17:0] m);
		logic [8:0] pt;
		int         e;
		pt = leg_t;
		for (int i = 0; i < 9; i++)
		begin
			rise_t[i] = 0;
			same_n[i] = 0;
			high_n[i] = 0;
		end
		repeat (64)
		begin
			@(posedge aclk);
			for (int i = 0; i < 9; i++)
			begin
				rise_t[i] += (leg_t[i] === 1'h1 && pt[i] === 1'h0);
				same_n[i] += (leg_t[i] === leg_c[i]);
				high_n[i] += (leg_t[i] !== 1'h0 || leg_c[i] !== 1'h0);
			end
			pt = leg_t;
		end
		for (int i = 0; i < 9; i++)
		begin
			e = (m[2*i +: 2] == 2'h1) ? 32 : (m[2*i +: 2] == 2'h2) ? 8 : 0;
			check($sformatf("rises_pair%0d", i), rise_t[i], e);
			if (e == 0)
				check($sformatf("high_pair%0d", i), high_n[i], 0);
			else
				check($sformatf("equal_pair%0d", i), same_n[i], 0);
		end
	endtask

	// Main sequence
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		// Supply good needs its synchroniser filled before the bus answers OKAY
		repeat (3) @(posedge aclk);
		rd_chk("oe100", `CCG_ADDR_OE100, 32'h3f);
		rd_chk("oe25", `CCG_ADDR_OE25, 32'h4);
		rd_chk("oemx", `CCG_ADDR_OEMX, 32'h6);
		rd_chk("mxsel", `CCG_ADDR_MXSEL, 32'h0);
		rd_chk("mask", `CCG_ADDR_IRQMSK, 32'h0);
		repeat (20) @(posedge aclk);
		wr(`CCG_ADDR_IRQST, 32'hf);
		rd_chk("irq_st", `CCG_ADDR_IRQST, 32'h0);
		check("miss_oe", platform_time_missing_n_oe, 1'h1);
		check("miss_o", platform_time_missing_n_o, 1'h0);
		rd_chk("status", `CCG_ADDR_STAT, 32'h1ff4);
		check_pairs(18'h16555);
		wr(`CCG_ADDR_MXSEL, 32'h6);
		repeat (16) @(posedge aclk);
		check_pairs(18'h2a555);
		// Partial disable with runt watch; strobe-less write ignored
		mon_on = 1'h1;
		wr(`CCG_ADDR_OE100, 32'h2a);
		wr(`CCG_ADDR_OE25, 32'h0);
		wr(`CCG_ADDR_OEMX, 32'h2);
		axi_write(`CCG_ADDR_OE100, 32'h3f, 4'h0, resp);
		check("bresp_nostrb", resp, `CCG_RESP_OKAY);
		repeat (16) @(posedge aclk);
		rd_chk("oe100", `CCG_ADDR_OE100, 32'h2a);
		rd_chk("status", `CCG_ADDR_STAT, 32'haa4);
		check_pairs(18'h08444);
		wr(`CCG_ADDR_OE100, 32'h3f);
		wr(`CCG_ADDR_OE25, 32'h4);
		wr(`CCG_ADDR_OEMX, 32'h6);
		repeat (16) @(posedge aclk);
		check_pairs(18'h2a555);
		// Supply loss gates every pair and refuses the bus
		supply_good_in <= 1'h0;
		repeat (20) @(posedge aclk);
		check_pairs(18'h0);
		axi_write(`CCG_ADDR_OE100, 32'h0, 4'hf, resp);
		check("bresp_off", resp, `CCG_RESP_SLVERR);
		axi_read(`CCG_ADDR_OE100, rd, resp);
		check("rresp_off", resp, `CCG_RESP_SLVERR);
		check("rdata_off", rd, 32'h0);
		supply_good_in <= 1'h1;
		repeat (20) @(posedge aclk);
		check("runts", runts, 0);
		mon_on = 1'h0;
		rd_chk("oe100", `CCG_ADDR_OE100, 32'h3f);
		check_pairs(18'h2a555);
		rd_chk("irq_st", `CCG_ADDR_IRQST, 32'hc);
		wr(`CCG_ADDR_IRQST, 32'hf);
		// Reference arrives, then interrupt mask and clear
		ref_on <= 1'h1;
		repeat (40) @(posedge aclk);
		check("miss_oe", platform_time_missing_n_oe, 1'h0);
		rd_chk("status", `CCG_ADDR_STAT, 32'h1ffd);
		rd_chk("irq_st", `CCG_ADDR_IRQST, 32'h2);
		check("irq_masked", irq, 1'h0);
		wr(`CCG_ADDR_IRQMSK, 32'h2);
		repeat (3) @(posedge aclk);
		check("irq_on", irq, 1'h1);
		wr(`CCG_ADDR_IRQST, 32'h2);
		repeat (3) @(posedge aclk);
		check("irq_clr", irq, 1'h0);
		// Reference lost: back to the crystal
		ref_on <= 1'h0;
		repeat (60) @(posedge aclk);
		check("miss_oe", platform_time_missing_n_oe, 1'h1);
		rd_chk("status", `CCG_ADDR_STAT, 32'h1ff4);
		rd_chk("irq_st", `CCG_ADDR_IRQST, 32'h1);
		check("irq_lost", irq, 1'h0);
		check_pairs(18'h2a555);
		// Unmapped place
		axi_read(8'h1c, rd, resp);
		check("rresp_unmapped", resp, `CCG_RESP_SLVERR);
		check("rdata_unmapped", rd, 32'h0);
		axi_write(8'h1c, 32'h1, 4'hf, resp);
		check("bresp_unmapped", resp, `CCG_RESP_SLVERR);
		end_sim();
	end
endmodule // clock_output_gate_and_ref_select_test
`default_nettype wire
